//--- hw/fbc_pkg.sv
// Summary of operation
// R01: one single-beat read or write per cycle
// R02: activate the row before accessing it
// R03: memory starts access at given column
// R04: all port signals timed on rising edge
// R05: active-low select and strobe command encoding
// R06: SDRAM bank pin, row, column address layout
// R07: SGRAM selects, address bank, row, column layout
// R08: SDRAM precharge one or all banks
// R09: SGRAM precharge one or all banks
// R10: clock enable high, special function low
// R11: byte mask zero-delay writes, two-delay reads
// R12: first command on first edge after reset
// R13: precharge all, then load mode, then operate
// R14: mode burst length field zero, single column
// R15: mode latency two or three, capture accordingly
// R16: memory keeps mode until reloaded
// R17: mixed bank parts run as two-bank
// R18: unsupported mixed or eight-part configurations
// R19: 8Mbit 8MByte uses both external selects
// R20: either 64-bit lane placement, by config
// R21: SDRAM reuses select pin, 64-bit only
// R22: memory setup comes from config inputs
// R23: no-op command on idle cycles
package fbc_pkg;

  localparam int unsigned DQ_W   = 128;
  localparam int unsigned MASK_W = 16;
  localparam int unsigned ADDR_W = 11;
  localparam int unsigned ROW_W  = 11;
  localparam int unsigned COL_W  = 8;

  // strobes as {row, col, write}
  localparam logic [2:0] STB_NOP  = 3'h7;
  localparam logic [2:0] STB_ACT  = 3'h3;
  localparam logic [2:0] STB_RD   = 3'h5;
  localparam logic [2:0] STB_WR   = 3'h4;
  localparam logic [2:0] STB_PCHG = 3'h2;
  localparam logic [2:0] STB_MODE = 3'h0;

  localparam int unsigned SD_ALL_BIT  = 10;
  localparam int unsigned SG_ALL_BIT  = 9;
  localparam int unsigned SG_BANK_BIT = 10;

  localparam int unsigned MR_BL_LSB = 0;
  localparam int unsigned MR_CL_LSB = 4;
  localparam logic [2:0]  MR_BL_ONE = 3'h0;
  localparam logic [2:0]  MR_CL2    = 3'h2;
  localparam logic [2:0]  MR_CL3    = 3'h3;

  // memory timing in memory clock periods, one period per system clock
  localparam int unsigned T_RP_TCK  = 4;
  localparam int unsigned T_MRD_TCK = 2;
  localparam int unsigned T_RCD_TCK = 3;
  localparam int unsigned T_RAS_TCK = 7;
  localparam int unsigned T_RC_TCK  = 10;
  localparam int unsigned T_WR_TCK  = 2;
  localparam int unsigned RP_CYC    = T_RP_TCK;
  localparam int unsigned MRD_CYC   = T_MRD_TCK;
  localparam int unsigned RCD_CYC   = T_RCD_TCK;
  localparam int unsigned RAS_CYC   = T_RAS_TCK;
  localparam int unsigned RC_CYC    = T_RC_TCK;
  localparam int unsigned WR_CYC    = T_WR_TCK;

  localparam logic [MASK_W-1:0] RST_MASK = 16'hFFFF;

  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PCHG, CMD_MODE
  } fbc_cmd_t;

  function automatic logic [DQ_W-1:0] fbc_map_data(input logic [DQ_W-1:0] d,
                                                   input logic wide, input logic upper);
    if (wide) return d;
    else if (upper) return {32'h0, d[63:32], 32'h0, d[31:0]};
    else return {64'h0, d[63:0]};
  endfunction

  function automatic logic [DQ_W-1:0] fbc_unmap_data(input logic [DQ_W-1:0] d,
                                                     input logic wide, input logic upper);
    if (wide) return d;
    else if (upper) return {64'h0, d[95:64], d[31:0]};
    else return {64'h0, d[63:0]};
  endfunction

  // unpopulated lanes stay masked
  function automatic logic [MASK_W-1:0] fbc_map_mask(input logic [MASK_W-1:0] m,
                                                     input logic wide, input logic upper);
    if (wide) return m;
    else if (upper) return {4'hF, m[7:4], 4'hF, m[3:0]};
    else return {8'hFF, m[7:0]};
  endfunction

endpackage

//--- hw/fbc_cmd_enc.sv
`timescale 1ns/1ps
module fbc_cmd_enc
  import fbc_pkg::*;
(
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst_b,
  input  wire fbc_cmd_t          i_cmd,
  input  wire logic              i_sgram,
  input  wire logic              i_two_ext,
  input  wire logic              i_ext,
  input  wire logic              i_bank,
  input  wire logic              i_all,
  input  wire logic [ROW_W-1:0]  i_row,
  input  wire logic [COL_W-1:0]  i_col,
  input  wire logic [ADDR_W-1:0] i_mode_op,
  input  wire logic [MASK_W-1:0] i_mask,
  input  wire logic [DQ_W-1:0]   i_wdata,
  output logic                   o_mem_select0_n,
  output logic                   o_mem_select1_or_bank_n,
  output logic                   o_row_strobe_n,
  output logic                   o_col_strobe_n,
  output logic                   o_write_strobe_n,
  output logic [ADDR_W-1:0]      o_mem_addr,
  output logic [MASK_W-1:0]      o_byte_mask,
  output logic [DQ_W-1:0]        o_mem_dq_out,
  output logic                   o_mem_dq_oe,
  output logic                   o_mem_clock_enable,
  output logic                   o_special_function_sel
);

  logic [2:0]        stb;
  logic [ADDR_W-1:0] addr;
  logic              sel0_n;
  logic              sel1_n;
  logic              bcast;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    stb   = STB_NOP;
    addr  = '0;
    bcast = (i_cmd == CMD_MODE) || (i_cmd == CMD_PCHG && i_all);
    // R05 command strobe encoding
    case (i_cmd)
      CMD_ACT:  stb = STB_ACT;
      CMD_RD:   stb = STB_RD;
      CMD_WR:   stb = STB_WR;
      CMD_PCHG: stb = STB_PCHG;
      CMD_MODE: stb = STB_MODE;
      default:  stb = STB_NOP;
    endcase
    // R06 R07 address layout per type
    case (i_cmd)
      CMD_ACT:  addr = i_sgram ? {i_bank, i_row[9:0]} : i_row;
      CMD_RD,
      CMD_WR:   addr = i_sgram ? {i_bank, 2'h0, i_col} : {3'h0, i_col};
      CMD_PCHG: begin
        // R08 R09 single or all banks
        if (i_sgram) begin
          addr[SG_BANK_BIT] = i_bank;
          addr[SG_ALL_BIT]  = i_all;
        end else begin
          addr[SD_ALL_BIT] = i_all;
        end
      end
      CMD_MODE: addr = i_mode_op;
      default:  addr = '0;
    endcase
    // R19 R21 select pins by memory type
    if (i_sgram) begin
      sel0_n = i_two_ext && i_ext && !bcast;
      sel1_n = i_two_ext && !i_ext && !bcast;
    end else begin
      sel0_n = 1'b0;
      sel1_n = (i_cmd == CMD_NOP) ? 1'b1 : ((i_cmd == CMD_MODE) ? 1'b0 : i_bank);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // R04 every pin launched from a rising-edge flop
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      {o_row_strobe_n, o_col_strobe_n, o_write_strobe_n} <= STB_NOP;
      o_mem_select0_n         <= 1'b0;
      o_mem_select1_or_bank_n <= 1'b0;
      o_mem_addr              <= '0;
      o_byte_mask             <= RST_MASK;
      o_mem_dq_out            <= '0;
      o_mem_dq_oe             <= 1'b0;
    end else begin
      {o_row_strobe_n, o_col_strobe_n, o_write_strobe_n} <= stb;
      o_mem_select0_n         <= sel0_n;
      o_mem_select1_or_bank_n <= sel1_n;
      o_mem_addr              <= addr;
      // R11 write mask and data share the cycle
      o_byte_mask             <= i_mask;
      o_mem_dq_out            <= i_wdata;
      o_mem_dq_oe             <= (i_cmd == CMD_WR);
    end
  end

  // R10 clock enable high, special function low
  always_ff @(posedge i_clk_sys) begin
    o_mem_clock_enable     <= 1'b1;
    o_special_function_sel <= 1'b0;
  end

endmodule

//--- hw/fbc_rd_cap.sv
`timescale 1ns/1ps
module fbc_rd_cap
  import fbc_pkg::*;
(
  input  wire logic            i_clk_sys,
  input  wire logic            i_rst_b,
  input  wire logic            i_rd_issue,
  input  wire logic            i_lat3,
  input  wire logic            i_wide,
  input  wire logic            i_upper,
  input  wire logic [DQ_W-1:0] i_mem_dq,
  output logic                 o_rd_valid,
  output logic [DQ_W-1:0]      o_rd_data
);

  // latency plus two input flops
  logic [4:0]      pipe_reg;
  logic [DQ_W-1:0] dq_ff1_reg;
  logic [DQ_W-1:0] dq_ff2_reg;
  logic            take;

  always_ff @(posedge i_clk_sys) begin
    dq_ff1_reg <= i_mem_dq;
    dq_ff2_reg <= dq_ff1_reg;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) pipe_reg <= '0;
    else pipe_reg <= {pipe_reg[3:0], i_rd_issue};
  end

  // R15 capture at programmed latency
  // issue seen on pins, so pipe_reg[0] lags the command by one edge
  assign take = i_lat3 ? pipe_reg[4] : pipe_reg[3];

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_rd_valid <= 1'b0;
      o_rd_data  <= '0;
    end else begin
      o_rd_valid <= take;
      // R20 gather populated lanes
      if (take) o_rd_data <= fbc_unmap_data(dq_ff2_reg, i_wide, i_upper);
    end
  end

  rd_lat2_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // R15
    (pipe_reg[0] && !i_lat3) |-> ##4 o_rd_valid)
    else $error("read data not returned at latency two");

  rd_lat3_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // R15
    (pipe_reg[0] && i_lat3) |-> ##5 o_rd_valid)
    else $error("read data not returned at latency three");

endmodule

//--- hw/fbc_ctrl.sv
`timescale 1ns/1ps
module fbc_ctrl
  import fbc_pkg::*;
#(
  parameter int unsigned AGE_W = 4
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst_b,
  input  wire logic              i_cfg_sgram,
  input  wire logic              i_cfg_bus128,
  input  wire logic              i_cfg_upper_lanes,
  input  wire logic              i_cfg_two_ext_banks,
  input  wire logic              i_cfg_read_lat3,
  input  wire logic              i_req_valid,
  input  wire logic              i_req_write,
  input  wire logic              i_req_ext_bank,
  input  wire logic              i_req_bank,
  input  wire logic [ROW_W-1:0]  i_req_row,
  input  wire logic [COL_W-1:0]  i_req_col,
  input  wire logic [DQ_W-1:0]   i_req_wdata,
  input  wire logic [MASK_W-1:0] i_req_wmask,
  input  wire logic [DQ_W-1:0]   i_mem_dq,
  output logic                   o_req_ready,
  output logic                   o_rd_valid,
  output logic [DQ_W-1:0]        o_rd_data,
  output logic                   o_mem_select0_n,
  output logic                   o_mem_select1_or_bank_n,
  output logic                   o_row_strobe_n,
  output logic                   o_col_strobe_n,
  output logic                   o_write_strobe_n,
  output logic [ADDR_W-1:0]      o_mem_addr,
  output logic [MASK_W-1:0]      o_byte_mask,
  output logic [DQ_W-1:0]        o_mem_dq_out,
  output logic                   o_mem_dq_oe,
  output logic                   o_mem_clock_enable,
  output logic                   o_special_function_sel
);

  localparam int unsigned REQ_W  = 3 + ROW_W + COL_W + DQ_W + MASK_W;
  localparam int unsigned WAIT_W = 3;

  typedef enum logic [2:0] {
    S_INIT_PCHG, S_INIT_PWAIT, S_INIT_MODE, S_WAIT, S_RUN
  } fbc_state_t;

  fbc_state_t        state_reg;
  fbc_state_t        state_next;
  fbc_cmd_t          cmd;
  logic [WAIT_W-1:0] wait_reg;
  logic [WAIT_W-1:0] wait_next;
  logic              all_bank;

  logic [REQ_W-1:0]  q_reg [2];
  logic [1:0]        q_cnt_reg;
  logic [1:0]        q_cnt_next;
  logic              push;
  logic              pop;

  logic              head_we;
  logic              head_ext;
  logic              head_bank;
  logic [ROW_W-1:0]  head_row;
  logic [COL_W-1:0]  head_col;
  logic [DQ_W-1:0]   head_wdata;
  logic [MASK_W-1:0] head_wmask;

  logic [ROW_W-1:0]  open_row_reg [4];
  logic [3:0]        open_vld_reg;
  logic [1:0]        idx;
  logic              head_open;
  logic              head_hit;

  logic [AGE_W-1:0]  act_age_reg;
  logic [AGE_W-1:0]  wr_age_reg;
  logic [1:0]        rd_gap_reg;
  logic              rd_last_reg;
  logic              rd_mask_now;

  logic              wide;
  logic              two_ext;
  logic              ext_eff;
  logic [2:0]        cl;
  logic [ADDR_W-1:0] mode_op;
  logic [MASK_W-1:0] mask_now;

  ////////////////////////////////////////////////////////////////////////////////
  // R22 setup from config inputs
  // R21 SDRAM forces the 64-bit path
  assign wide    = i_cfg_bus128 && i_cfg_sgram;
  // R18 R19 second external bank only for 128-bit SGRAM
  assign two_ext = i_cfg_two_ext_banks && wide;
  assign cl      = i_cfg_read_lat3 ? MR_CL3 : MR_CL2;
  // R14 R15 burst one, chosen latency, burst type zero
  assign mode_op = (ADDR_W'(cl) << MR_CL_LSB) | (ADDR_W'(MR_BL_ONE) << MR_BL_LSB);

  assign {head_we, head_ext, head_bank, head_row, head_col, head_wdata, head_wmask} = q_reg[0];
  assign ext_eff = head_ext && two_ext;
  // R17 one bank bit, so every part runs as two-bank
  assign idx       = {ext_eff, head_bank};
  assign head_open = open_vld_reg[idx];
  assign head_hit  = head_open && (open_row_reg[idx] == head_row);

  ////////////////////////////////////////////////////////////////////////////////
  // R23 idle cycles default to no-op
  always_comb begin
    cmd        = CMD_NOP;
    all_bank   = 1'b0;
    state_next = state_reg;
    wait_next  = (wait_reg == '0) ? wait_reg : wait_reg - 1'b1;
    case (state_reg)
      // R12 R13 precharge all first, right after reset
      S_INIT_PCHG: begin
        cmd        = CMD_PCHG;
        all_bank   = 1'b1;
        wait_next  = WAIT_W'(RP_CYC - 1);
        state_next = S_INIT_PWAIT;
      end
      S_INIT_PWAIT: begin
        if (wait_reg == '0) state_next = S_INIT_MODE;
      end
      // R13 mode load before any operation
      S_INIT_MODE: begin
        cmd        = CMD_MODE;
        wait_next  = WAIT_W'(MRD_CYC - 1);
        state_next = S_WAIT;
      end
      S_WAIT: begin
        if (wait_reg == '0) state_next = S_RUN;
      end
      S_RUN: begin
        if (q_cnt_reg != 2'h0) begin
          if (head_hit) begin
            // R01 hits issue back to back, except a write after a read waits for rd_gap_reg to drain
            if (!head_we) cmd = CMD_RD;
            else if (rd_gap_reg == 2'h0) cmd = CMD_WR;
          end else if (head_open) begin
            if (act_age_reg >= RAS_CYC && wr_age_reg >= WR_CYC) begin
              cmd        = CMD_PCHG;
              wait_next  = WAIT_W'(RP_CYC - 1);
              state_next = S_WAIT;
            end
          end else if (act_age_reg >= RC_CYC) begin
            // R02 open the row before the access
            cmd        = CMD_ACT;
            wait_next  = WAIT_W'(RCD_CYC - 1);
            state_next = S_WAIT;
          end
        end
      end
      default: state_next = S_INIT_PCHG;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      state_reg <= S_INIT_PCHG;
      wait_reg  <= '0;
    end else begin
      state_reg <= state_next;
      wait_reg  <= wait_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // two-slot request queue keeps ready registered at full rate
  assign push       = i_req_valid && o_req_ready;
  assign pop        = (cmd == CMD_RD) || (cmd == CMD_WR);
  assign q_cnt_next = q_cnt_reg + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      q_cnt_reg   <= 2'h0;
      o_req_ready <= 1'b0;
    end else begin
      q_cnt_reg   <= q_cnt_next;
      o_req_ready <= (q_cnt_next != 2'h2);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    case ({push, pop})
      2'b10: q_reg[q_cnt_reg[0]] <= {i_req_write, i_req_ext_bank, i_req_bank, i_req_row,
                                     i_req_col, i_req_wdata, i_req_wmask};
      2'b11: q_reg[0] <= {i_req_write, i_req_ext_bank, i_req_bank, i_req_row,
                          i_req_col, i_req_wdata, i_req_wmask};
      2'b01: q_reg[0] <= q_reg[1];
      default: q_reg[0] <= q_reg[0];
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      open_vld_reg <= 4'h0;
    end else if (cmd == CMD_ACT) begin
      open_vld_reg[idx] <= 1'b1;
      open_row_reg[idx] <= head_row;
    end else if (cmd == CMD_PCHG) begin
      if (all_bank) open_vld_reg <= 4'h0;
      else open_vld_reg[idx] <= 1'b0;
    end
  end

  // ages saturate; reset to max so the first activate is not delayed
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      act_age_reg <= '1;
      wr_age_reg  <= '1;
    end else begin
      if (cmd == CMD_ACT) act_age_reg <= AGE_W'(1);
      else if (act_age_reg != '1) act_age_reg <= act_age_reg + 1'b1;
      if (cmd == CMD_WR) wr_age_reg <= AGE_W'(1);
      else if (wr_age_reg != '1) wr_age_reg <= wr_age_reg + 1'b1;
    end
  end

  // bus turnaround: no write until read data has left the bus
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      rd_gap_reg  <= 2'h0;
      rd_last_reg <= 1'b0;
    end else begin
      rd_last_reg <= (cmd == CMD_RD);
      if (cmd == CMD_RD) rd_gap_reg <= cl[1:0];
      else if (rd_gap_reg != 2'h0) rd_gap_reg <= rd_gap_reg - 2'h1;
    end
  end

  // R11 read mask leads the data by two clocks
  assign rd_mask_now = i_cfg_read_lat3 ? rd_last_reg : (cmd == CMD_RD);

  // R20 lanes follow the configured placement
  always_comb begin
    if (cmd == CMD_WR) mask_now = fbc_map_mask(head_wmask, wide, i_cfg_upper_lanes);
    else if (rd_mask_now) mask_now = fbc_map_mask('0, wide, i_cfg_upper_lanes);
    else mask_now = RST_MASK;
  end

  ////////////////////////////////////////////////////////////////////////////////
  fbc_cmd_enc u_enc (
    .i_clk_sys               (i_clk_sys),
    .i_rst_b                 (i_rst_b),
    .i_cmd                   (cmd),
    .i_sgram                 (i_cfg_sgram),
    .i_two_ext               (two_ext),
    .i_ext                   (ext_eff),
    .i_bank                  (head_bank),
    .i_all                   (all_bank),
    .i_row                   (head_row),
    .i_col                   (head_col),
    .i_mode_op               (mode_op),
    .i_mask                  (mask_now),
    .i_wdata                 (fbc_map_data(head_wdata, wide, i_cfg_upper_lanes)),
    .o_mem_select0_n         (o_mem_select0_n),
    .o_mem_select1_or_bank_n (o_mem_select1_or_bank_n),
    .o_row_strobe_n          (o_row_strobe_n),
    .o_col_strobe_n          (o_col_strobe_n),
    .o_write_strobe_n        (o_write_strobe_n),
    .o_mem_addr              (o_mem_addr),
    .o_byte_mask             (o_byte_mask),
    .o_mem_dq_out            (o_mem_dq_out),
    .o_mem_dq_oe             (o_mem_dq_oe),
    .o_mem_clock_enable      (o_mem_clock_enable),
    .o_special_function_sel  (o_special_function_sel)
  );

  logic [2:0] pin_stb;
  logic       pin_rd;
  logic       pin_wr;
  logic       pin_act;
  logic       pin_pchg;
  logic       pin_mode;

  assign pin_stb  = {o_row_strobe_n, o_col_strobe_n, o_write_strobe_n};
  assign pin_rd   = (pin_stb == STB_RD);
  assign pin_wr   = (pin_stb == STB_WR);
  assign pin_act  = (pin_stb == STB_ACT);
  assign pin_pchg = (pin_stb == STB_PCHG);
  assign pin_mode = (pin_stb == STB_MODE);

  // R15 capture at latency, issue seen on the pins
  fbc_rd_cap u_cap (
    .i_clk_sys  (i_clk_sys),
    .i_rst_b    (i_rst_b),
    .i_rd_issue (pin_rd),
    .i_lat3     (i_cfg_read_lat3),
    .i_wide     (wide),
    .i_upper    (i_cfg_upper_lanes),
    .i_mem_dq   (i_mem_dq),
    .o_rd_valid (o_rd_valid),
    .o_rd_data  (o_rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  logic rst_seen_reg;
  logic mode_seen_reg;

  always_ff @(posedge i_clk_sys) begin
    rst_seen_reg <= !i_rst_b;
    if (!i_rst_b) mode_seen_reg <= 1'b0;
    else if (pin_mode) mode_seen_reg <= 1'b1;
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  sequence s_rw_quiet;
    (!pin_rd && !pin_wr) [*2];
  endsequence

  sequence s_act_quiet;
    (!pin_act) [*3];
  endsequence

  init_pchg_a: assert property ( // R12
    (rst_seen_reg && i_rst_b) |=>
      pin_pchg && (i_cfg_sgram ? o_mem_addr[SG_ALL_BIT] : o_mem_addr[SD_ALL_BIT]))
    else $error("first command after reset is not precharge all");

  mode_first_a: assert property ( // R13
    (pin_rd || pin_wr || pin_act) |-> mode_seen_reg)
    else $error("operational command before mode load");

  act_to_rw_a: assert property ( // R02
    pin_act |-> ##1 s_rw_quiet)
    else $error("access too soon after activate");

  pchg_gap_a: assert property ( // R13
    pin_pchg |-> ##1 s_act_quiet)
    else $error("activate too soon after precharge");

  mode_value_a: assert property ( // R14
    pin_mode |-> o_mem_addr[2:0] == MR_BL_ONE && o_mem_addr[6:4] == cl ##1 !pin_stb[2] == 1'b0)
    else $error("mode load value or spacing wrong");

  cke_dsf_a: assert property ( // R10
    ##1 (o_mem_clock_enable && !o_special_function_sel))
    else $error("clock enable or special function wrong");

  col_addr_a: assert property ( // R06
    (pin_rd || pin_wr) |-> (i_cfg_sgram ? !o_mem_addr[SG_ALL_BIT] : !o_mem_addr[SD_ALL_BIT]))
    else $error("access address bit not zero");

  rd_mask_a: assert property ( // R11
    (pin_rd && !i_cfg_read_lat3) |-> o_byte_mask == fbc_map_mask('0, wide, i_cfg_upper_lanes))
    else $error("read mask not enabled two clocks ahead");

  wr_oe_a: assert property ( // R11
    pin_wr |-> o_mem_dq_oe ##1 (!pin_wr || o_mem_dq_oe))
    else $error("write data not driven with command");

  turnaround_a: assert property ( // R11
    pin_rd |-> ##1 (!pin_wr) [*2])
    else $error("write collides with read data");

endmodule

//--- verif/fbc_mem_model.sv
`timescale 1ns/1ps
module fbc_mem_model
  import fbc_pkg::*;
(
  input  wire logic              i_clk_sys,
  input  wire logic              i_lat3,
  input  wire logic              i_mem_select0_n,
  input  wire logic              i_row_strobe_n,
  input  wire logic              i_col_strobe_n,
  input  wire logic              i_write_strobe_n,
  input  wire logic [ADDR_W-1:0] i_mem_addr,
  input  wire logic [MASK_W-1:0] i_byte_mask,
  input  wire logic [DQ_W-1:0]   i_mem_dq_out,
  output logic      [DQ_W-1:0]   o_mem_dq
);
  logic [DQ_W-1:0]   store [int];
  logic [9:0]        open_row [2];
  logic [DQ_W-1:0]   pd1, pd2, pd3, d, tmp;
  logic              pv1 = 1'b0, pv2 = 1'b0, pv3 = 1'b0, v;
  logic [MASK_W-1:0] mk1, mk2;
  logic [2:0]        stb;
  int                key;
  assign stb = {i_row_strobe_n, i_col_strobe_n, i_write_strobe_n};
  assign d = i_lat3 ? pd3 : pd2;
  assign v = i_lat3 ? pv3 : pv2;
  always_comb begin
    for (int i = 0; i < MASK_W; i++) o_mem_dq[8*i+:8] = (v && !mk2[i]) ? d[8*i+:8] : ~d[8*i+:8];
  end
  always @(posedge i_clk_sys) begin
    key = {i_mem_addr[10], open_row[i_mem_addr[10]], i_mem_addr[7:0]};
    mk1 <= i_byte_mask;
    mk2 <= mk1;
    pv1 <= !i_mem_select0_n && stb == STB_RD;
    pd1 <= store.exists(key) ? store[key] : '0;
    {pv2, pv3, pd2, pd3} <= {pv1, pv2, pd1, pd2};
    if (!i_mem_select0_n && stb == STB_ACT) open_row[i_mem_addr[10]] <= i_mem_addr[9:0];
    if (!i_mem_select0_n && stb == STB_WR) begin
      tmp = store.exists(key) ? store[key] : '0;
      for (int i = 0; i < MASK_W; i++) if (!i_byte_mask[i]) tmp[8*i+:8] = i_mem_dq_out[8*i+:8];
      store[key] = tmp;
    end
  end
endmodule

//--- verif/framebuffer_sdram_sgram_command_ctrl_bench.sv
`timescale 1ns/1ps
module framebuffer_sdram_sgram_command_ctrl_bench;
  import fbc_pkg::*;
  logic              clk, rst_b, lat3, valid, wr, ext, bank, ready, rv;
  logic              s0, s1, ras, cas, we, cke, special_function_sel, oe;
  logic [ROW_W-1:0]  row;
  logic [COL_W-1:0]  col;
  logic [ADDR_W-1:0] addr;
  logic [MASK_W-1:0] wm, bm;
  logic [DQ_W-1:0]   wd, rd, dq, dq_o, e;
  logic [DQ_W-1:0]   shadow [int];
  logic [DQ_W-1:0]   exp_q [$];
  int                err_total = 0, n_tests = 0, cyc = 0, k;

  fbc_ctrl u_dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_cfg_sgram(1'b1), .i_cfg_bus128(1'b1),
    .i_cfg_upper_lanes(1'b0), .i_cfg_two_ext_banks(1'b0), .i_cfg_read_lat3(lat3),
    .i_req_valid(valid), .i_req_write(wr), .i_req_ext_bank(ext), .i_req_bank(bank),
    .i_req_row(row), .i_req_col(col), .i_req_wdata(wd), .i_req_wmask(wm), .i_mem_dq(dq),
    .o_req_ready(ready), .o_rd_valid(rv), .o_rd_data(rd), .o_mem_select0_n(s0),
    .o_mem_select1_or_bank_n(s1), .o_row_strobe_n(ras), .o_col_strobe_n(cas),
    .o_write_strobe_n(we), .o_mem_addr(addr), .o_byte_mask(bm), .o_mem_dq_out(dq_o),
    .o_mem_dq_oe(oe), .o_mem_clock_enable(cke), .o_special_function_sel(special_function_sel));
  fbc_mem_model u_mem (.i_clk_sys(clk), .i_lat3(lat3), .i_mem_select0_n(s0),
    .i_row_strobe_n(ras), .i_col_strobe_n(cas), .i_write_strobe_n(we), .i_mem_addr(addr),
    .i_byte_mask(bm), .i_mem_dq_out(dq_o), .o_mem_dq(dq));

  task chk(input string nm, input logic [DQ_W-1:0] ex, input logic [DQ_W-1:0] got);
    n_tests++;
    if (ex !== got) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
      err_total++;
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic logic [DQ_W-1:0] merge(input logic [DQ_W-1:0] o, n, input logic [15:0] m);
    for (int i = 0; i < MASK_W; i++) if (!m[i]) o[8*i+:8] = n[8*i+:8];
    return o;
  endfunction

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (rv === 1'b1) begin
      e = exp_q.size() ? exp_q.pop_front() : ~rd;
      chk("rdata", e, rd);
    end
    if ({ras, cas, we} == STB_WR) chk("write drive", 1'b1, oe);
    if (!(ras && cas && we)) chk("selects", '0, {s0, s1});
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end
  initial begin
    void'($urandom(32'h3EC0588C));
    {rst_b, valid, wr, ext, bank, row, col, wd, wm} = '0;
    lat3 = 1'($urandom);
    // second pass: reset mid-run, other latency, memory contents kept
    for (int p = 0; p < 2; p++) begin
      rst_b <= 1'b0;
      if (p != 0) lat3 <= !lat3;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      #1;
      chk("pchg", {1'b0, STB_PCHG, 1'b1}, {s0, ras, cas, we, addr[SG_ALL_BIT]});
      chk("enable pins", 2'h2, {cke, special_function_sel});
      // four idle cycles after the precharge, mode on the fifth
      repeat (5) @(posedge clk);
      #1;
      e = DQ_W'({1'b0, STB_MODE, 4'h0, lat3 ? MR_CL3 : MR_CL2, 4'h0});
      chk("mode", e, DQ_W'({s0, ras, cas, we, addr}));
      @(posedge clk);
      for (int i = 0; i < 200; i++) begin
        wr <= (i % 16 < 2) ? 1'b1 : 1'($urandom);
        ext <= 1'($urandom);
        bank <= 1'($urandom);
        row <= 11'($urandom % 4);
        col <= 8'($urandom % 8);
        wd <= {$urandom, $urandom, $urandom, $urandom};
        wm <= (i % 16 == 0) ? 16'hFFFF : (i % 16 == 1) ? 16'h0000 : 16'($urandom);
        valid <= 1'b1;
        do @(posedge clk); while (ready !== 1'b1);
        k = {bank, row[9:0], col};
        e = shadow.exists(k) ? shadow[k] : '0;
        if (wr) shadow[k] = merge(e, wd, wm);
        else exp_q.push_back(e);
      end
      valid <= 1'b0;
      repeat (40) @(posedge clk);
      chk("reads left", '0, DQ_W'(exp_q.size()));
    end
    end_sim();
  end
endmodule
